// ---- core/rrm_bank.sv ----
/*
  rrm_bank: upper register bank of the radio with reset and read-back
  behaviour, reached through the serial port's byte-level access strobes.
  assumes: the serial front end delivers decoded one-cycle read and write
  strobes in the I_CLK domain; regulator, monitor and transceiver status
  levels arrive from other domains and are synchronised here.
*/
`timescale 1ns/1ps
module rrm_bank
  import rrm_pkg::*;
(
  input  wire logic            I_CLK,
  input  wire logic            I_RST_N,
  input  wire logic            I_POR,
  input  wire logic            I_PIN_RST_N,
  input  wire logic            I_RD,
  input  wire logic            I_WR,
  input  wire logic [AW-1:0]   I_ADDR,
  input  wire logic [DW-1:0]   I_WDATA,
  input  wire logic            I_DIG_REG_ON,
  input  wire logic            I_BAT_MON_ON,
  input  wire logic            I_PON_STATE,
  input  wire logic [DW-1:0]   I_PHASE_VALUE,
  output logic      [DW-1:0]   O_RDATA,
  output logic                 O_RVALID,
  output logic      [DW-1:0]   O_RETRY_CTRL,
  output logic      [DW-1:0]   O_SEED_LOW,
  output logic      [DW-1:0]   O_SEED_HIGH,
  output logic      [DW-1:0]   O_BE_LIMITS,
  output logic      [DW-1:0]   O_DIG_TEST,
  output logic      [DW-1:0]   O_TX_TIMING,
  output logic      [DW-1:0]   O_GAIN_TEST,
  output logic      [DW-1:0]   O_MOD_TEST
);
  // ---------------------------------------------------------------
  // synchronisers for pins and foreign status levels
  // ---------------------------------------------------------------
  logic [4:0] meta_reg;
  logic [4:0] meta_next;
  logic [4:0] sync_reg;
  logic [4:0] sync_next;
  // two flops on every foreign level; only the second flop is ever read
  always_comb begin
    meta_next = {I_POR, I_PIN_RST_N, I_DIG_REG_ON, I_BAT_MON_ON, I_PON_STATE};
    sync_next = meta_reg;
  end
  always_ff @(posedge I_CLK) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end
  wire logic por_s     = sync_reg[4];
  wire logic pin_rst_s = ~sync_reg[3];
  wire logic dreg_on   = sync_reg[2];
  wire logic bat_on    = sync_reg[1];
  wire logic pon_s     = sync_reg[0];
  // the block reset also counts as power-on so no register is ever unset
  wire logic por       = por_s | ~I_RST_N;

  // ---------------------------------------------------------------
  // reset kind, remembered for the transceiver state read-back
  // ---------------------------------------------------------------
  rrm_rst_kind_t kind_reg;
  rrm_rst_kind_t kind_next;
  always_comb begin
    kind_next = kind_reg;
    if (por) begin
      kind_next = RRM_RST_POWER_ON;
    end else if (pin_rst_s) begin
      kind_next = pon_s ? RRM_RST_PIN_PON : RRM_RST_PIN_OTHER;
    end
  end
  always_ff @(posedge I_CLK) begin
    kind_reg <= kind_next;
  end

  // ---------------------------------------------------------------
  // writable registers
  // ---------------------------------------------------------------
  localparam int NRW = 7;
  localparam logic [AW-1:0] RW_ADDR [NRW] = '{ADDR_EXT_ADDR7, ADDR_RETRY_CTRL,
    ADDR_SEED_LOW, ADDR_SEED_HIGH, ADDR_BE_LIMITS, ADDR_GAIN_TEST, ADDR_MOD_TEST};
  localparam logic [DW-1:0] RW_RST [NRW] = '{RST_ZERO, RST_RETRY_CTRL,
    RST_SEED_LOW, RST_SEED_HIGH, RST_BE_LIMITS, RST_ZERO, RST_ZERO};
  localparam logic [DW-1:0] FULL_WMASK = '1;
  // test control nibble plus the two page selects; the rest stays zero
  localparam logic [DW-1:0] DIG_WMASK  = MASK_DIG_TEST | DW'(1 << BIT_PHASE_PAGE)
    | DW'(1 << BIT_TXTIME_PAGE);
  typedef enum logic [1:0] {
    RRM_PAGE_NONE,
    RRM_PAGE_PHASE,
    RRM_PAGE_TXTIME
  } rrm_page_t;
  logic [DW-1:0]  rw_q [NRW];
  logic [DW-1:0]  dig_q;
  logic [DW-1:0]  txt_q;
  logic           txt_page;
  logic           phase_page;
  rrm_page_t      page_view;
  logic [NRW-1:0] we_rw;
  logic           we_dig;
  logic           we_txt;
  assign phase_page = dig_q[BIT_PHASE_PAGE];
  assign txt_page   = dig_q[BIT_TXTIME_PAGE];
  // phase page wins when both selects are set, so a timing write cannot
  // slip in while software believes it is reading measurements
  always_comb begin
    page_view = RRM_PAGE_NONE;
    if (phase_page) begin
      page_view = RRM_PAGE_PHASE;
    end else if (txt_page) begin
      page_view = RRM_PAGE_TXTIME;
    end
  end
  always_comb begin
    we_rw = '0;
    for (int i = 0; i < NRW; i++) begin
      we_rw[i] = I_WR && I_ADDR == RW_ADDR[i];
    end
    we_dig = I_WR && I_ADDR == ADDR_DIG_TEST;
    // tx timing writes land only while its page is selected
    we_txt = I_WR && I_ADDR == ADDR_PAGED && page_view == RRM_PAGE_TXTIME;
  end
  // pin reset leaves the writable bank untouched; only power-on reloads
  for (genvar g = 0; g < NRW; g++) begin : g_rw
    rrm_byte_reg #(.RST_VAL(RW_RST[g]), .WMASK(FULL_WMASK)) u_reg (
      .i_clk  (I_CLK),
      .i_por  (por),
      .i_we   (we_rw[g]),
      .i_wdata(I_WDATA),
      .o_q    (rw_q[g])
    );
  end
  rrm_byte_reg #(.RST_VAL(RST_ZERO), .WMASK(DIG_WMASK)) u_dig (
    .i_clk  (I_CLK),
    .i_por  (por),
    .i_we   (we_dig),
    .i_wdata(I_WDATA),
    .o_q    (dig_q)
  );
  rrm_byte_reg #(.RST_VAL(RST_ZERO), .WMASK(FULL_WMASK)) u_txt (
    .i_clk  (I_CLK),
    .i_por  (por),
    .i_we   (we_txt),
    .i_wdata(I_WDATA),
    .o_q    (txt_q)
  );

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;
  logic          rvalid_reg;
  logic          rvalid_next;
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = I_RD && !por;
    if (I_RD) begin
      rdata_next = RST_ZERO; // unmapped and reserved read zero
      for (int i = 0; i < NRW; i++) begin
        if (I_ADDR == RW_ADDR[i]) begin
          rdata_next = rw_q[i];
        end
      end
      case (I_ADDR)
        ADDR_REG_CTRL: begin
          rdata_next = dreg_on ? RD_REG_CTRL_ON : RST_ZERO;
        end
        ADDR_BAT_MON: begin
          rdata_next = (bat_on && pon_s) ? RD_BAT_MON_PON : RST_BAT_MON;
        end
        ADDR_XCVR_STATE: begin
          case (kind_reg)
            RRM_RST_POWER_ON:  rdata_next = RD_XCVR_PON;
            RRM_RST_PIN_PON:   rdata_next = RD_XCVR_PON;
            RRM_RST_PIN_OTHER: rdata_next = RD_XCVR_OTHER;
            default:           rdata_next = RST_ZERO;
          endcase
        end
        ADDR_DIG_TEST: begin
          rdata_next = dig_q;
        end
        ADDR_PAGED: begin
          if (phase_page) begin
            rdata_next = I_PHASE_VALUE;
          end else if (txt_page) begin
            rdata_next = txt_q;
          end else begin
            rdata_next = RST_ZERO;
          end
        end
        default: begin
        end
      endcase
    end
    if (por) begin
      rdata_next = RST_ZERO;
    end
  end
  always_ff @(posedge I_CLK) begin
    rdata_reg  <= rdata_next;
    rvalid_reg <= rvalid_next;
  end

  // ---------------------------------------------------------------
  // outputs, each registered
  // ---------------------------------------------------------------
  assign O_RDATA      = rdata_reg;
  assign O_RVALID     = rvalid_reg;
  assign O_RETRY_CTRL = rw_q[1];
  assign O_SEED_LOW   = rw_q[2];
  assign O_SEED_HIGH  = rw_q[3];
  assign O_BE_LIMITS  = rw_q[4];
  assign O_DIG_TEST   = dig_q;
  assign O_TX_TIMING  = txt_q;
  assign O_GAIN_TEST  = rw_q[5];
  assign O_MOD_TEST   = rw_q[6];
endmodule : rrm_bank

// ---- core/rrm_byte_reg.sv ----
/*
  rrm_byte_reg: one writable byte register with a power-on default.
  assumes: write strobe and address decode come from the bank.
*/
`timescale 1ns/1ps
module rrm_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK   = 8'hff
) (
  input  wire logic       i_clk,
  input  wire logic       i_por,
  input  wire logic       i_we,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_q
);
  logic [7:0] q_reg;
  logic [7:0] q_next;

  always_comb begin
    q_next = q_reg;
    if (i_por) begin
      q_next = RST_VAL;
    end else if (i_we) begin
      q_next = i_wdata & WMASK;
    end
  end

  always_ff @(posedge i_clk) begin
    q_reg <= q_next;
  end

  assign o_q = q_reg;
endmodule : rrm_byte_reg

// ---- core/rrm_pkg.sv ----
/*
  rrm_pkg: register offsets, reset values, read-back values and page
  select encodings for the radio register bank.
  assumes: 8-bit data, 6-bit register address space.
*/
package rrm_pkg;
  localparam int unsigned AW = 6;
  localparam int unsigned DW = 8;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_TRX_STATUS  = 6'h01;
  localparam logic [AW-1:0] ADDR_REG_CTRL    = 6'h10;
  localparam logic [AW-1:0] ADDR_BAT_MON     = 6'h11;
  localparam logic [AW-1:0] ADDR_EXT_ADDR7   = 6'h2b;
  localparam logic [AW-1:0] ADDR_RETRY_CTRL  = 6'h2c;
  localparam logic [AW-1:0] ADDR_SEED_LOW    = 6'h2d;
  localparam logic [AW-1:0] ADDR_SEED_HIGH   = 6'h2e;
  localparam logic [AW-1:0] ADDR_BE_LIMITS   = 6'h2f;
  localparam logic [AW-1:0] ADDR_XCVR_STATE  = 6'h30;
  localparam logic [AW-1:0] ADDR_DIG_TEST    = 6'h36;
  localparam logic [AW-1:0] ADDR_PAGED       = 6'h3b;
  localparam logic [AW-1:0] ADDR_GAIN_TEST   = 6'h3c;
  localparam logic [AW-1:0] ADDR_MOD_TEST    = 6'h3d;
  // ---------------------------------------------------------------
  // power-on reset values
  // ---------------------------------------------------------------
  localparam logic [DW-1:0] RST_ZERO         = 8'h00;
  localparam logic [DW-1:0] RST_BAT_MON      = 8'h02;
  localparam logic [DW-1:0] RST_RETRY_CTRL   = 8'h38;
  localparam logic [DW-1:0] RST_SEED_LOW     = 8'hea;
  localparam logic [DW-1:0] RST_SEED_HIGH    = 8'h42;
  localparam logic [DW-1:0] RST_BE_LIMITS    = 8'h53;
  // ---------------------------------------------------------------
  // practical read-back values
  // ---------------------------------------------------------------
  localparam logic [DW-1:0] RD_REG_CTRL_ON   = 8'h04;
  localparam logic [DW-1:0] RD_BAT_MON_PON   = 8'h22;
  localparam logic [DW-1:0] RD_XCVR_PON      = 8'h11;
  localparam logic [DW-1:0] RD_XCVR_OTHER    = 8'h07;
  localparam logic [DW-1:0] PAGE_SEL_ON      = 8'h01;
  // digital_test_control keeps its test control field in the low nibble
  localparam logic [DW-1:0] MASK_DIG_TEST    = 8'h0f;
  // phase and timing page selects live in the digital test register
  localparam int unsigned   BIT_PHASE_PAGE   = 4;
  localparam int unsigned   BIT_TXTIME_PAGE  = 5;
  typedef enum logic [1:0] {
    RRM_RST_NONE,
    RRM_RST_POWER_ON,
    RRM_RST_PIN_PON,
    RRM_RST_PIN_OTHER
  } rrm_rst_kind_t;
endpackage : rrm_pkg

// ---- tb/rrm_bank_props.sv ----
/* rrm_bank_chk: port assertions for the radio register bank.
   assumes: bound to rrm_bank; status levels held 4 edges before a read. */
`timescale 1ns/1ps
module rrm_bank_chk
  import rrm_pkg::*;
(
  input wire logic          I_CLK,
  input wire logic          I_RST_N,
  input wire logic          I_POR,
  input wire logic          I_PIN_RST_N,
  input wire logic          I_RD,
  input wire logic          I_WR,
  input wire logic [AW-1:0] I_ADDR,
  input wire logic [DW-1:0] I_WDATA,
  input wire logic          I_DIG_REG_ON,
  input wire logic          I_BAT_MON_ON,
  input wire logic          I_PON_STATE,
  input wire logic [DW-1:0] I_PHASE_VALUE,
  input wire logic [DW-1:0] O_RDATA,
  input wire logic [DW-1:0] O_SEED_LOW,
  input wire logic [DW-1:0] O_TX_TIMING
);
  // shadow of the page selects and of any pin reset since block reset
  logic [1:0] pg_reg, pg_next;
  logic       pin_reg, pin_next;
  always_comb begin
    pg_next = (I_WR && I_ADDR == ADDR_DIG_TEST) ? I_WDATA[5:4] : pg_reg;
    pin_next = pin_reg | !I_PIN_RST_N;
  end
  always_ff @(posedge I_CLK) begin
    pg_reg <= (!I_RST_N || I_POR) ? 2'h0 : pg_next;
    pin_reg <= !I_RST_N ? 1'h0 : pin_next;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  AST_POR_LOAD: assert property (I_POR[*5] |-> O_SEED_LOW == RST_SEED_LOW)
    else $error("seed low missed its default after power-on reset");
  AST_PIN_KEEP: assert property (!I_PIN_RST_N && !I_WR && !I_POR |=> $stable(O_SEED_LOW))
    else $error("pin reset changed seed low");
  AST_REG_ON: assert property (I_DIG_REG_ON[*4] ##0 (I_RD && I_ADDR == ADDR_REG_CTRL)
    |=> O_RDATA == RD_REG_CTRL_ON) else $error("regulator read wrong");
  AST_BAT_PON: assert property ((I_BAT_MON_ON && I_PON_STATE)[*4] ##0
    (I_RD && I_ADDR == ADDR_BAT_MON) |=> O_RDATA == RD_BAT_MON_PON) else $error("monitor read wrong");
  AST_XCVR_PON: assert property (I_RD && I_ADDR == ADDR_XCVR_STATE && !pin_reg
    |=> O_RDATA == RD_XCVR_PON) else $error("state register read wrong");
  AST_PHASE_RD: assert property (I_RD && I_ADDR == ADDR_PAGED && pg_reg[0]
    |=> O_RDATA == $past(I_PHASE_VALUE)) else $error("phase page read wrong");
  AST_TX_WR: assert property (I_WR && I_ADDR == ADDR_PAGED && pg_reg == 2'h2
    |=> O_TX_TIMING == $past(I_WDATA)) else $error("timing write lost");
  AST_TX_HOLD: assert property (I_WR && I_ADDR == ADDR_PAGED && pg_reg[0]
    |=> $stable(O_TX_TIMING)) else $error("timing written on phase page");
  AST_RST_LOAD: assert property ($rose(I_RST_N) |-> O_SEED_LOW == RST_SEED_LOW
    && O_TX_TIMING == RST_ZERO) else $error("defaults missing after reset");
  cover property (I_RD && I_ADDR == ADDR_PAGED && pg_reg[0]);
  cover property ($rose(I_PIN_RST_N));
  cover property (I_POR[*5]);
endmodule : rrm_bank_chk
bind rrm_bank rrm_bank_chk u_chk (.I_CLK, .I_RST_N, .I_POR, .I_PIN_RST_N, .I_RD, .I_WR,
  .I_ADDR, .I_WDATA, .I_DIG_REG_ON, .I_BAT_MON_ON, .I_PON_STATE, .I_PHASE_VALUE,
  .O_RDATA, .O_SEED_LOW, .O_TX_TIMING);

// ---- tb/rrm_host.sv ----
/* rrm_host: host side of the register port, byte reads and writes.
   assumes: one access at a time, strobe one edge long. */
`timescale 1ns/1ps
module rrm_host
  import rrm_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic [DW-1:0] i_rdata,
  input  wire logic          i_rvalid,
  output logic               o_rd = 1'h0,
  output logic               o_wr = 1'h0,
  output logic      [AW-1:0] o_addr = 6'h00,
  output logic      [DW-1:0] o_wdata = 8'h00
);
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clk);
    o_wr <= 1'h1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'h0;
  endtask : wr
  // the strobe is taken at one edge; data and valid stand at the next one
  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic v);
    @(posedge i_clk);
    o_rd <= 1'h1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'h0;
    @(posedge i_clk);
    v = i_rvalid;
    d = i_rdata;
  endtask : rd
endmodule : rrm_host

// ---- tb/testbench.sv ----
/* testbench: scenarios for the radio register bank.
   assumes: 25 MHz clock, host model drives the register port. */
`timescale 1ns/1ps
module testbench;
  import rrm_pkg::*;
  logic          clk, rst_n, por, pin_n, rd, wr, dig_on, bat_on, pon, rvalid;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, phase, rdata, q, seed_lo, txt;
  logic [DW-1:0] retry, seed_hi, be_lim, dig, gain, modt;
  int            mismatches, n_checks, cycles;
  rrm_bank u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_POR(por), .I_PIN_RST_N(pin_n),
    .I_RD(rd), .I_WR(wr), .I_ADDR(addr), .I_WDATA(wdata), .I_DIG_REG_ON(dig_on),
    .I_BAT_MON_ON(bat_on), .I_PON_STATE(pon), .I_PHASE_VALUE(phase), .O_RDATA(rdata),
    .O_RVALID(rvalid), .O_RETRY_CTRL(retry), .O_SEED_LOW(seed_lo), .O_SEED_HIGH(seed_hi),
    .O_BE_LIMITS(be_lim), .O_DIG_TEST(dig), .O_TX_TIMING(txt), .O_GAIN_TEST(gain),
    .O_MOD_TEST(modt));
  rrm_host u_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_rd(rd), .o_wr(wr),
    .o_addr(addr), .o_wdata(wdata));
  task automatic chk(input string s, input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] e);
    logic v;
    u_host.rd(a, q, v);
    chk("read valid", 8'h01, {7'h00, v});
    chk($sformatf("reg %h", a), e, q);
  endtask : rchk
  task automatic end_of_test;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    logic [AW-1:0] ad [10] = '{ADDR_EXT_ADDR7, ADDR_RETRY_CTRL, ADDR_SEED_LOW, ADDR_SEED_HIGH,
      ADDR_BE_LIMITS, ADDR_DIG_TEST, ADDR_PAGED, ADDR_GAIN_TEST, ADDR_MOD_TEST, 6'h3f};
    logic [DW-1:0] ev [10] = '{RST_ZERO, RST_RETRY_CTRL, RST_SEED_LOW, RST_SEED_HIGH,
      RST_BE_LIMITS, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
    chk("tx timing", RST_ZERO, txt);
    chk("retry ctrl", RST_RETRY_CTRL, retry);
    chk("seed high", RST_SEED_HIGH, seed_hi);
    chk("be limits", RST_BE_LIMITS, be_lim);
    chk("dig test", RST_ZERO, dig);
    chk("gain test", RST_ZERO, gain);
    chk("mod test", RST_ZERO, modt);
    for (int k = 0; k < 10; k++) begin
      rchk(ad[k], ev[k]);
    end
  endtask : t_defaults
  task automatic t_status;
    rchk(ADDR_REG_CTRL, RD_REG_CTRL_ON);
    rchk(ADDR_BAT_MON, RD_BAT_MON_PON);
    rchk(ADDR_XCVR_STATE, RD_XCVR_PON);
    @(posedge clk);
    dig_on <= 1'h0;
    pon <= 1'h0;
    repeat (4) @(posedge clk);
    rchk(ADDR_REG_CTRL, RST_ZERO);
    rchk(ADDR_BAT_MON, RST_BAT_MON);
  endtask : t_status
  // pin reset outside the power-on state must spare written registers
  task automatic t_pin;
    u_host.wr(ADDR_SEED_LOW, 8'h5a);
    pin_n <= 1'h0;
    repeat (4) @(posedge clk);
    pin_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk("seed low", 8'h5a, seed_lo);
    rchk(ADDR_SEED_LOW, 8'h5a);
    rchk(ADDR_XCVR_STATE, RD_XCVR_OTHER);
  endtask : t_pin
  task automatic t_paged;
    @(posedge clk);
    phase <= 8'h3c;
    u_host.wr(ADDR_DIG_TEST, 8'h20);
    u_host.wr(ADDR_PAGED, 8'ha5);
    rchk(ADDR_PAGED, 8'ha5);
    u_host.wr(ADDR_DIG_TEST, 8'h30);
    u_host.wr(ADDR_PAGED, 8'h11);
    rchk(ADDR_PAGED, 8'h3c);
    chk("tx timing", 8'ha5, txt);
    chk("dig test", 8'h30, dig);
    u_host.wr(ADDR_DIG_TEST, 8'hff);
    rchk(ADDR_DIG_TEST, 8'h3f);
  endtask : t_paged
  task automatic t_por;
    u_host.wr(ADDR_SEED_LOW, 8'h77);
    por <= 1'h1;
    repeat (6) @(posedge clk);
    por <= 1'h0;
    repeat (4) @(posedge clk);
    rchk(ADDR_SEED_LOW, RST_SEED_LOW);
    rchk(ADDR_XCVR_STATE, RD_XCVR_PON);
  endtask : t_por
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    {rst_n, por, pin_n, dig_on, bat_on, pon} = 6'h0f;
    phase = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_defaults();
    t_status();
    t_pin();
    t_paged();
    t_por();
    end_of_test();
  end
endmodule : testbench
